// File: hdl/artc_pkg.sv
/*
  Constants for the auto-reload timer with capture: register byte
  offsets, field positions, reset values, clock select codes, dividers.
  Assumes a 32-bit APB bus with byte addresses.
*/
`default_nettype none
package artc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00; // timer_control_reg
  localparam logic [7:0] OFS_RLD_LO = 8'h04; // reload_lo
  localparam logic [7:0] OFS_RLD_HI = 8'h08; // reload_hi
  localparam logic [7:0] OFS_CNT_LO = 8'h0c; // count_lo
  localparam logic [7:0] OFS_CNT_HI = 8'h10; // count_hi
  localparam logic [7:0] OFS_CLKCTL = 8'h14; // clock_control_reg
  localparam logic [7:0] OFS_IRQEN  = 8'h18; // ext_irq_enable_reg
  localparam logic [7:0] OFS_ISTAT  = 8'h1c; // interrupt status
  localparam logic [7:0] OFS_IMASK  = 8'h20; // interrupt mask
  // ==========================================================
  // Control register fields
  localparam int CTL_HI_FLAG = 7;
  localparam int CTL_LO_FLAG = 6;
  localparam int CTL_LO_IE   = 5;
  localparam int CTL_CAP_EN  = 4;
  localparam int CTL_SPLIT   = 3;
  localparam int CTL_RUN     = 2;
  localparam int CTL_ALT_HI  = 1;
  localparam int CTL_ALT_LO  = 0;
  // Clock control, irq enable, status fields
  localparam int CLK_LO_SYS  = 0;
  localparam int CLK_HI_SYS  = 1;
  localparam int IE_TIMER    = 0;
  localparam int IST_HI      = 0;
  localparam int IST_LO      = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ  = 2'h0;
  // ==========================================================
  // Alternate clock select codes
  localparam logic [1:0] ALT_DIV12 = 2'h0;
  localparam logic [1:0] ALT_RTC   = 2'h1;
  localparam logic [1:0] ALT_RSVD  = 2'h2;
  localparam logic [1:0] ALT_EXT8  = 2'h3;
  // Dividers
  localparam int unsigned SYS_DIV  = 12;
  localparam int unsigned EXT_DIV  = 8;
endpackage
`default_nettype wire

// File: hdl/artc_sync.sv
/*
  Synchroniser for an oscillator pin with a rising-edge divider.
  Assumes async_i is unrelated to clk_i; emits one pulse per DIV edges.
*/
`timescale 1ns/100ps
`default_nettype none
module artc_sync #(
  parameter int unsigned DIV = 1
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Pin side
  input  wire logic async_i,
  // Event out
  output var  logic event_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          s3;
    logic          filt;
    logic [CW-1:0] cnt;
    logic          ev;
  } artc_sync_t;
  artc_sync_t r, next_r;
  logic rise;

  // ==========================================================
  // Filtered level moves only when stages two and three agree
  assign rise = (r.s2 == r.s3) && r.s3 && !r.filt;
  always_comb begin
    next_r    = r;
    next_r.s1 = async_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.ev = 1'b0;
    if (r.s2 == r.s3) begin
      next_r.filt = r.s3;
    end
    if (rise) begin
      if (r.cnt == CW'(DIV - 1)) begin
        next_r.cnt = '0;
        next_r.ev  = 1'b1;
      end else begin
        next_r.cnt = r.cnt + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign event_o = r.ev;

  // A pulse needs DIV filtered rising edges, so never two in a row
  ev_single_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.ev |=> !r.ev) else $error("pin event lasted two cycles");
endmodule // artc_sync
`default_nettype wire

// File: hdl/artc_timer.sv
/*
  Auto-reload timer with capture: 16-bit or split 8-bit counting,
  period capture of two oscillator pins, APB registers, one irq line.
  Assumes one 40 MHz clock and oscillator pins unrelated to it.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
// Summary of operation
// - Counter is two bytes, 16-bit or split
// - Split clear runs one 16-bit reload counter
// - 16-bit wrap loads reload, sets high flag; with capture on, code wraps to zero and sets no high flag
// - Timer irq enabled interrupts on 16-bit overflow; code gives no request for it while capture is on
// - Low-byte enable adds interrupt on low wrap
// - Split runs two 8-bit reload counters
// - Split: run gates high only, low free
// - Per-byte system_clock bit, else alternate select
// - Oscillator inputs synchronised before counting
// - Split: each byte wrap sets its flag; code sets no high flag on a high wrap while capture is on
// - Split: high always, low if enabled, interrupt; code gives no high request while capture is on
// - Flags only cleared by software
// - Capture source chosen by alternate select bit
// - Capture copies count to reload, sets flag
`timescale 1ns/100ps
`default_nettype none
module artc_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // Oscillator pins
  input  wire logic        rtc_osc_i,
  input  wire logic        ext_osc_i,
  // Interrupt
  output var  logic        irq_o
);
  // Whole block state; one copy is built, one is registered
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  rld_lo;
    logic [7:0]  rld_hi;
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
    logic [1:0]  clk;
    logic        ie;
    logic [1:0]  ist;
    logic [1:0]  imask;
    logic [3:0]  d12;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } artc_state_t;
  artc_state_t r, next_r;

  logic        rtc_ev, ext_ev, d12_tk, lo_tk, hi_tk, cap_ev;
  logic        split, cap, run, done, wr;
  logic        lo_ovf, hi_ovf;
  logic [1:0]  alt;
  logic [15:0] cnt16;

  // ==========================================================
  // Source selection for one count byte
  function automatic logic tick_sel(input logic sys, input logic [1:0] a,
                                    input logic t12, input logic trtc,
                                    input logic text);
    if (sys) begin
      tick_sel = 1'b1;
    end else begin
      unique case (a)
        artc_pkg::ALT_DIV12: tick_sel = t12;
        artc_pkg::ALT_RTC:   tick_sel = trtc;
        artc_pkg::ALT_RSVD:  tick_sel = 1'b0; // Reserved never counts
        artc_pkg::ALT_EXT8:  tick_sel = text;
      endcase
    end
  endfunction

  // Register read decode; top bit (bit 32) flags a miss
  // Unmapped words answer with an error and zero data
  function automatic logic [32:0] rd_mux(input artc_state_t s,
                                         input logic [7:0] a);
    rd_mux = '0;
    unique case (a)
      artc_pkg::OFS_CTRL:   rd_mux[7:0] = s.ctl;
      artc_pkg::OFS_RLD_LO: rd_mux[7:0] = s.rld_lo;
      artc_pkg::OFS_RLD_HI: rd_mux[7:0] = s.rld_hi;
      artc_pkg::OFS_CNT_LO: rd_mux[7:0] = s.cnt_lo;
      artc_pkg::OFS_CNT_HI: rd_mux[7:0] = s.cnt_hi;
      artc_pkg::OFS_CLKCTL: rd_mux[1:0] = s.clk;
      artc_pkg::OFS_IRQEN:  rd_mux[0]   = s.ie;
      artc_pkg::OFS_ISTAT:  rd_mux[1:0] = s.ist;
      artc_pkg::OFS_IMASK:  rd_mux[1:0] = s.imask;
      default:              rd_mux[32]  = 1'b1;
    endcase
  endfunction

  // ==========================================================
  // Oscillator pins: synchronised, then rtc per edge, ext per 8
  // Divider counts filtered edges, so a slow pin loses none
  artc_sync #(.DIV(1)) u_rtc (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (rtc_osc_i),
    .event_o (rtc_ev)
  );
  artc_sync #(.DIV(artc_pkg::EXT_DIV)) u_ext (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (ext_osc_i),
    .event_o (ext_ev)
  );

  // ==========================================================
  // Decoded mode and tick terms
  assign split  = r.ctl[artc_pkg::CTL_SPLIT];
  assign cap    = r.ctl[artc_pkg::CTL_CAP_EN];
  assign run    = r.ctl[artc_pkg::CTL_RUN];
  assign alt    = r.ctl[artc_pkg::CTL_ALT_HI:artc_pkg::CTL_ALT_LO];
  assign cnt16  = {r.cnt_hi, r.cnt_lo};
  assign d12_tk = (r.d12 == 4'(artc_pkg::SYS_DIV - 1));
  assign lo_tk  = tick_sel(r.clk[artc_pkg::CLK_LO_SYS], alt, d12_tk,
                           rtc_ev, ext_ev);
  assign hi_tk  = tick_sel(r.clk[artc_pkg::CLK_HI_SYS], alt, d12_tk,
                           rtc_ev, ext_ev);
  // Alternate select bit one picks the capture trigger
  // Capture ignores run: the pin event alone copies the count
  assign cap_ev = cap && (alt[1] ? ext_ev : rtc_ev);
  assign done   = psel_i && penable_i && r.pready;
  assign wr     = done && pwrite_i;

  // ==========================================================
  // Next-state logic: count, capture, flags, bus
  always_comb begin
    logic [32:0] rd;
    rd     = rd_mux(r, paddr_i);
    next_r = r;
    lo_ovf = 1'b0;
    hi_ovf = 1'b0;
    // Free-running divide by twelve; its phase is unknown to software
    next_r.d12 = d12_tk ? 4'h0 : r.d12 + 4'h1;
    if (!split) begin
      // One 16-bit counter on the low byte source
      if (lo_tk && run) begin
        lo_ovf = (r.cnt_lo == 8'hff);
        hi_ovf = (cnt16 == 16'hffff);
        if (hi_ovf && !cap) begin
          {next_r.cnt_hi, next_r.cnt_lo} = {r.rld_hi, r.rld_lo};
        end else begin
          {next_r.cnt_hi, next_r.cnt_lo} = cnt16 + 16'h0001;
        end
      end
    end else begin
      // Low byte always runs in split mode
      if (lo_tk) begin
        lo_ovf = (r.cnt_lo == 8'hff);
        next_r.cnt_lo = lo_ovf ? r.rld_lo : r.cnt_lo + 8'h01;
      end
      if (hi_tk && run) begin
        hi_ovf = (r.cnt_hi == 8'hff);
        next_r.cnt_hi = hi_ovf ? r.rld_hi : r.cnt_hi + 8'h01;
      end
    end
    // Capture snapshots the count as it stood before this tick
    if (cap_ev) begin
      {next_r.rld_hi, next_r.rld_lo} = cnt16;
    end
    // Bus: one wait state, then the access completes
    // The wait state keeps the read mux off the setup cycle
    next_r.pready = psel_i && penable_i && !r.pready;
    if (psel_i && penable_i && !r.pready) begin
      next_r.prdata  = rd[31:0];
      next_r.pslverr = rd[32];
    end
    if (done && !pwrite_i && paddr_i == artc_pkg::OFS_ISTAT) begin
      // Clear only the bits returned, so a fresh event survives
      next_r.ist = r.ist & ~r.prdata[1:0];
    end
    if (wr) begin
      unique case (paddr_i)
        artc_pkg::OFS_CTRL:   next_r.ctl    = pwdata_i[7:0];
        artc_pkg::OFS_RLD_LO: next_r.rld_lo = pwdata_i[7:0];
        artc_pkg::OFS_RLD_HI: next_r.rld_hi = pwdata_i[7:0];
        artc_pkg::OFS_CNT_LO: next_r.cnt_lo = pwdata_i[7:0];
        artc_pkg::OFS_CNT_HI: next_r.cnt_hi = pwdata_i[7:0];
        artc_pkg::OFS_CLKCTL: next_r.clk    = pwdata_i[1:0];
        artc_pkg::OFS_IRQEN:  next_r.ie     = pwdata_i[0];
        artc_pkg::OFS_IMASK:  next_r.imask  = pwdata_i[1:0];
        default: ;
      endcase
    end
    // Hardware sets after software writes: set beats clear
    if ((hi_ovf && !cap) || cap_ev) begin
      next_r.ctl[artc_pkg::CTL_HI_FLAG] = 1'b1;
    end
    if (lo_ovf) begin
      next_r.ctl[artc_pkg::CTL_LO_FLAG] = 1'b1;
    end
    // Interrupt requests, sticky until read
    if (r.ie && ((hi_ovf && !cap) || cap_ev)) begin
      next_r.ist[artc_pkg::IST_HI] = 1'b1;
    end
    if (r.ie && r.ctl[artc_pkg::CTL_LO_IE] && lo_ovf) begin
      next_r.ist[artc_pkg::IST_LO] = 1'b1;
    end
    next_r.irq = |(next_r.ist & next_r.imask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r         <= '0;
      r.ctl     <= artc_pkg::RST_CTRL;
      r.rld_lo  <= artc_pkg::RST_BYTE;
      r.rld_hi  <= artc_pkg::RST_BYTE;
      r.cnt_lo  <= artc_pkg::RST_BYTE;
      r.cnt_hi  <= artc_pkg::RST_BYTE;
      r.ist     <= artc_pkg::RST_IRQ;
      r.imask   <= artc_pkg::RST_IRQ;
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register
  assign prdata_o  = r.prdata;
  assign pready_o  = r.pready;
  assign pslverr_o = r.pslverr;
  assign irq_o     = r.irq;

  // ==========================================================
  // Checks
  // Writes are excluded where software may overwrite the count
  sequence wide_tick_s;
    !split && !cap && run && lo_tk && !wr;
  endsequence
  sequence lo_wrap_s;
    lo_tk && r.cnt_lo == 8'hff && (split || run);
  endsequence

  ovf_reload_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wide_tick_s ##0 (cnt16 == 16'hffff) |=>
      cnt16 == $past({r.rld_hi, r.rld_lo}) && r.ctl[artc_pkg::CTL_HI_FLAG])
    else $error("16-bit wrap did not reload");
  wide_inc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wide_tick_s ##0 (cnt16 != 16'hffff) |=> cnt16 == $past(cnt16) + 16'h0001)
    else $error("16-bit count did not advance by one");
  sys_tick_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.clk[artc_pkg::CLK_LO_SYS] |-> lo_tk) else $error("system_clock select lost");
  ovf_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.ie ##0 wide_tick_s ##0 (cnt16 == 16'hffff) |=> r.ist[artc_pkg::IST_HI])
    else $error("overflow request missing");
  lo_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (r.ie && r.ctl[artc_pkg::CTL_LO_IE]) ##0 lo_wrap_s |=>
      r.ist[artc_pkg::IST_LO] && r.ctl[artc_pkg::CTL_LO_FLAG])
    else $error("low wrap request missing");
  split_rld_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (split && !wr) ##0 lo_wrap_s |=> r.cnt_lo == $past(r.rld_lo))
    else $error("split low byte did not reload");
  hi_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    split && !run && !wr |=> $stable(r.cnt_hi))
    else $error("stopped high byte moved");
  hi_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    split && run && hi_tk && r.cnt_hi == 8'hff |=> r.ctl[artc_pkg::CTL_HI_FLAG])
    else $error("split high wrap flag missing");
  flag_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.ctl[artc_pkg::CTL_HI_FLAG] && !wr |=> r.ctl[artc_pkg::CTL_HI_FLAG])
    else $error("high flag cleared by hardware");
  cap_copy_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cap_ev && !wr |=> {r.rld_hi, r.rld_lo} == $past(cnt16) ##0
      r.ctl[artc_pkg::CTL_HI_FLAG]) else $error("capture not stored");
  irq_line_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    |(r.ist & r.imask) && !done |=> irq_o) else $error("irq line low");

  // ==========================================================
  // Further checks: bus pulse, holds, split bytes, prescaler

  // Split high byte at its wrap, outside capture
  sequence hi_wrap_s;
    split && !cap && run && hi_tk && r.cnt_hi == 8'hff;
  endsequence
  // Split low byte on a tick below its wrap
  sequence lo_step_s;
    split && lo_tk && r.cnt_lo != 8'hff;
  endsequence

  // Ready is one pulse, so no access completes twice
  ready_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.pready |=> !r.pready) else $error("ready stood two cycles");
  // A miss returns zero data with its error
  miss_data_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.pready && r.pslverr |-> r.prdata == 32'h0) else $error("miss returned data");
  // Stopped wide counter moves only by a write
  wide_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !split && !run && !wr |=> $stable(cnt16))
    else $error("stopped 16-bit count moved");
  // Reserved source never advances the wide counter
  rsvd_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !split && !r.clk[artc_pkg::CLK_LO_SYS] && alt == artc_pkg::ALT_RSVD && !wr
      |=> $stable(cnt16)) else $error("reserved source counted");
  // Low wrap in wide mode carries into the high byte
  carry_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wide_tick_s ##0 (r.cnt_lo == 8'hff && r.cnt_hi != 8'hff) |=>
      r.cnt_hi == $past(r.cnt_hi) + 8'h01 && r.cnt_lo == 8'h00)
    else $error("low wrap did not carry");
  // Capture mode wraps freely; the flag belongs to captures
  cap_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !split && cap && run && lo_tk && !wr && cnt16 == 16'hffff |=> cnt16 == 16'h0000)
    else $error("capture mode reloaded");

  // Split low byte steps by one below its wrap
  split_inc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lo_step_s ##0 !wr |=> r.cnt_lo == $past(r.cnt_lo) + 8'h01)
    else $error("split low byte did not step");
  // Split high byte reloads from its own reload byte
  hi_rld_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    hi_wrap_s ##0 !wr |=> r.cnt_hi == $past(r.rld_hi))
    else $error("split high byte did not reload");
  // Split high wrap requests an interrupt when enabled
  hi_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.ie ##0 hi_wrap_s |=> r.ist[artc_pkg::IST_HI])
    else $error("split high request missing");
  // Low flag is as sticky as the high one
  lo_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    r.ctl[artc_pkg::CTL_LO_FLAG] && !wr |=> r.ctl[artc_pkg::CTL_LO_FLAG])
    else $error("low flag cleared by hardware");

  // Prescaler restarts after each divided tick
  d12_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    d12_tk |=> r.d12 == 4'h0) else $error("divide by twelve lost phase");
  // Nothing pending and no enable keeps the line low
  irq_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(|(r.ist & r.imask)) && !r.ie |=> !irq_o) else $error("irq line stuck high");
endmodule // artc_timer
`default_nettype wire

// File: dv/artc_timer_tb.sv
/*
  Self-checking bench for the auto-reload timer: APB tasks, pin pulses.
  Assumes artc_pkg and artc_timer are compiled first; one 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module artc_timer_tb;
  // ==========================================================
  // Signals and short register aliases
  logic        clk_i;
  logic        nrst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        rtc_osc_i;
  logic        ext_osc_i;
  logic        irq_o;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          rise_cyc;
  int          r1;
  logic [31:0] rv;
  logic        re;
  logic [15:0] cap1;
  localparam logic [7:0] A_CTL = artc_pkg::OFS_CTRL;
  localparam logic [7:0] A_RL  = artc_pkg::OFS_RLD_LO;
  localparam logic [7:0] A_RH  = artc_pkg::OFS_RLD_HI;
  localparam logic [7:0] A_CL  = artc_pkg::OFS_CNT_LO;
  localparam logic [7:0] A_CH  = artc_pkg::OFS_CNT_HI;
  localparam logic [7:0] A_CK  = artc_pkg::OFS_CLKCTL;
  localparam logic [7:0] A_ST  = artc_pkg::OFS_ISTAT;
  localparam logic [7:0] A_MK  = artc_pkg::OFS_IMASK;

  artc_timer uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rtc_osc_i(rtc_osc_i),
    .ext_osc_i(ext_osc_i), .irq_o(irq_o));

  // ==========================================================
  // Clock and cycle count for capture spacing
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // ==========================================================
  // Compare tasks, exact and windowed
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Window used where the prescaler phase is unknown
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] g);
    checks_done++;
    if ((g < lo) !== 1'b0 || (g > hi) !== 1'b0) begin
      error_cnt++;
      $display("wrong value %s expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask

  // ==========================================================
  // APB master: setup, access held until pready seen at an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rv = prdata_o;
    re = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) chk("pready_o", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  // Read with exact data; error response expected only past the map
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk("prdata_o", e, rv);
    chk("pslverr_o", {31'h0, a > A_MK}, {31'h0, re});
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 8'h00);
    chk_rng("prdata_o", lo, hi, rv);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq_o", 32'h1, {31'h0, irq_o});
  endtask
  // Oscillator pulses; long halves so the pin filter sees each level
  task automatic osc(input logic ext, input int n, input int half);
    repeat (n) begin
      if (ext) ext_osc_i <= 1'b1;
      else rtc_osc_i <= 1'b1;
      rise_cyc = cyc;
      wt(half);
      if (ext) ext_osc_i <= 1'b0;
      else rtc_osc_i <= 1'b0;
      wt(half);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog; the whole run needs under two thousand cycles
  initial begin
    wt(20000);
    error_cnt++;
    $display("wrong value watchdog expected done seen hang");
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, rtc_osc_i, ext_osc_i} = 6'h0;
    paddr_i  = 8'h00;
    pwdata_i = 32'h0;
    wt(5);
    nrst_i <= 1'b1;
    // Reset values and an unmapped word
    for (int a = 0; a <= 36; a += 4) rdc(a[7:0], 32'h0);
    // 16-bit wrap from 0xfff0 with reload 0x1234
    wr(A_CK, 8'h01);
    wr(artc_pkg::OFS_IRQEN, 8'h01);
    wr(A_MK, 8'h03);
    wr(A_RL, 8'h34);
    wr(A_RH, 8'h12);
    wr(A_CL, 8'hf0);
    wr(A_CH, 8'hff);
    wr(A_CTL, 8'h04);
    wait_irq();
    rdc(A_CTL, 32'hc4);
    rdc(A_CH, 32'h12);
    rdc(A_ST, 32'h1);
    rdc(A_ST, 32'h0);
    wt(2);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    rdc(A_CTL, 32'hc4);
    // Masked event: status set, line stays low
    wr(A_CTL, 8'h00);
    wr(A_MK, 8'h00);
    wr(A_CL, 8'hf0);
    wr(A_CH, 8'hff);
    wr(A_CTL, 8'h04);
    wt(40);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    rdc(A_ST, 32'h1);
    wr(A_MK, 8'h03);
    // Low byte wrap in 16-bit mode with its enable
    wr(A_CTL, 8'h00);
    wr(A_CH, 8'h00);
    wr(A_CL, 8'hf8);
    wr(A_CTL, 8'h24);
    wait_irq();
    rdc(A_ST, 32'h2);
    rdc(A_CTL, 32'h64);
    // Split mode, high byte stopped then run, low byte free running
    wr(A_CTL, 8'h00);
    wr(A_RL, 8'hf0);
    wr(A_CL, 8'hfe);
    wr(A_CH, 8'h50);
    wr(A_RH, 8'h80);
    wr(A_CTL, 8'h08);
    wt(20);
    rdc(A_CH, 32'h50);
    rdr(A_CL, 32'hf0, 32'hff);
    rdc(A_CTL, 32'h48);
    rdc(A_ST, 32'h0);
    wr(A_CK, 8'h03);
    wr(A_CH, 8'hfc);
    wr(A_CTL, 8'h0c);
    wait_irq();
    rdr(A_CH, 32'h80, 32'h8f);
    rdc(A_ST, 32'h1);
    rdc(A_CTL, 32'hcc);
    wr(A_CTL, 8'h28);
    wt(40);
    rdc(A_ST, 32'h2);
    // Alternate clock sources on the full counter
    wr(A_CTL, 8'h00);
    wr(A_CK, 8'h00);
    wr(A_CH, 8'h00);
    wr(A_CL, 8'h00);
    wr(A_CTL, 8'h04);
    wt(120);
    rdr(A_CL, 32'h9, 32'hb);
    for (int s = 1; s < 4; s++) begin
      wr(A_CTL, 8'h00);
      wr(A_CL, 8'h00);
      wr(A_CTL, 8'h04 | s[7:0]);
      if (s != 2) osc(s == 3, 16, 4);
      wt(60);
      rdc(A_CL, s == 1 ? 32'h10 : s == 3 ? 32'h2 : 32'h0);
    end
    // Capture on two rtc rises; count delta equals their spacing
    wr(A_CTL, 8'h00);
    wr(A_CK, 8'h01);
    wr(A_CTL, 8'h14);
    osc(1'b0, 1, 100);
    r1 = rise_cyc;
    apb(1'b0, A_RL, 8'h00);
    cap1[7:0] = rv[7:0];
    apb(1'b0, A_RH, 8'h00);
    cap1[15:8] = rv[7:0];
    osc(1'b0, 1, 100);
    apb(1'b0, A_RH, 8'h00);
    cap1 = {rv[7:0], 8'h00} - cap1;
    apb(1'b0, A_RL, 8'h00);
    cap1 = cap1 + {8'h00, rv[7:0]};
    chk("capture delta", 32'(16'(rise_cyc - r1)), {16'h0, cap1});
    // Low byte wrapped once during the captures
    rdc(A_CTL, 32'hd4);
    // External capture fires on the eighth edge only; count frozen
    wr(A_CK, 8'h00);
    wr(A_CTL, 8'h16);
    wr(A_RL, 8'h00);
    osc(1'b1, 7, 4);
    wt(8);
    rdc(A_CTL, 32'h16);
    osc(1'b1, 1, 4);
    wt(8);
    rdc(A_CTL, 32'h96);
    end_sim();
  end
endmodule // artc_timer_tb
`default_nettype wire
